// file: shared/ffdc_pkg.sv
// Package for the float format decoder and converter.
// Holds field positions, biases, limits and the carrier structs.
// Assumes every user refers to names as ffdc_pkg::name.
package ffdc_pkg;

    // ------------------------------------------------------------
    // Field layouts and biases
    // ------------------------------------------------------------
    localparam int DP_EXP_W   = 11;       // Exponent bits 62:52
    localparam int DP_FRAC_W  = 52;       // Fraction bits 51:0
    localparam int DP_BIAS    = 1023;     // Denormal scale uses 1022
    localparam int SP_EXP_W   = 8;        // Exponent bits 30:23
    localparam int SP_FRAC_W  = 23;       // Fraction bits 22:0
    localparam int SP_BIAS    = 127;      // Denormal scale uses 126
    localparam int HP_EXP_W   = 5;        // Exponent bits 14:10
    localparam int HP_FRAC_W  = 10;       // Fraction bits 9:0
    localparam int HP_BIAS    = 15;       // Denormal scale uses 14
    localparam int F11_FRAC_W = 6;        // Exponent bits 10:6, fraction 5:0
    localparam int F10_FRAC_W = 5;        // Exponent bits 9:5, fraction 4:0
    localparam int UF_EXP_W   = 5;
    localparam int UF_BIAS    = 15;

    // ------------------------------------------------------------
    // Shared-exponent RGB word
    // ------------------------------------------------------------
    localparam int RGB_EXP_LSB   = 27;    // Bits 31:27
    localparam int RGB_BLUE_LSB  = 18;    // Bits 26:18
    localparam int RGB_GREEN_LSB = 9;     // Bits 17:9
    localparam int RGB_RED_LSB   = 0;     // Bits 8:0
    localparam int RGB_CH_W      = 9;
    localparam int RGB_BIAS      = 15;

    // ------------------------------------------------------------
    // Single to half conversion limits
    // ------------------------------------------------------------
    localparam logic [7:0]  CVT_MIN_NORM_EXP = 8'h71;   // 113 maps to half exponent 1
    localparam logic [7:0]  CVT_OVF_EXP      = 8'h8f;   // 127+16 and above is infinity
    localparam logic [7:0]  CVT_REBIAS       = 8'h70;   // 112 = 127 - 15
    localparam logic [7:0]  CVT_DEN_BASE     = 8'h7e;   // 126, denormal shift origin
    localparam logic [7:0]  CVT_SHIFT_MAX    = 8'h19;   // 25, everything beyond is zero
    localparam logic [14:0] HP_INF_MAG       = 15'h7c00;
    localparam logic [9:0]  HP_QNAN_FRAC     = 10'h200;

    // ------------------------------------------------------------
    // Carrier structs
    // ------------------------------------------------------------
    typedef struct packed {
        logic               sign;     // Always 0 for unsigned formats
        logic               nan;
        logic               inf;
        logic               zero;
        logic               denorm;
        logic signed [12:0] exp;      // Unbiased power of two
        logic [52:0]        sig;      // Significand, hidden bit included
    } ffdc_class_t;

    typedef struct packed {
        logic signed [12:0] exp;      // Shared power, e minus 15
        logic [8:0]         red;      // 0.f significands
        logic [8:0]         green;
        logic [8:0]         blue;
    } ffdc_rgb_t;

endpackage

// file: hdl/ffdc_classify.sv
// Generic classifier for one binary float encoding.
// Combinational; the caller registers the result.
`timescale 1ns/1ps
module ffdc_classify #(
    parameter int EW   = 8,
    parameter int FW   = 23,
    parameter int BIAS = 127,
    parameter int SGN  = 1
) (
    input  wire logic [SGN+EW+FW-1:0] word_in,
    output ffdc_pkg::ffdc_class_t     class_out
);

    // ------------------------------------------------------------
    // Field split
    // ------------------------------------------------------------
    wire logic [EW-1:0] e       = word_in[EW+FW-1:FW];
    wire logic [FW-1:0] f       = word_in[FW-1:0];
    wire logic          e_ones  = &e;
    wire logic          e_zero  = ~|e;
    wire logic          f_zero  = ~|f;
    // Unsigned formats have no sign bit, so sign is forced low
    // no sign bit
    wire logic          s       = (SGN != 0) ? word_in[SGN+EW+FW-1] : 1'b0;

    // Class and value fields; denormals scale with bias minus one
    // special code classes
    assign class_out.sign   = s;
    assign class_out.nan    = e_ones & ~f_zero;
    assign class_out.inf    = e_ones & f_zero;
    assign class_out.zero   = e_zero & f_zero;
    assign class_out.denorm = e_zero & ~f_zero;
    assign class_out.exp    = e_zero ? 13'(1 - BIAS) : 13'(e) - 13'(BIAS);
    assign class_out.sig    = 53'({~e_zero & ~e_ones, f});

endmodule

// file: hdl/ffdc_top.sv
// Float format decoder and converter: classifies 64, 32, 16, 11 and
// 10 bit floats, splits the shared-exponent RGB word, and converts
// single to half precision with round to nearest even.
// Inputs are synchronous to clk_in; all results appear one edge later.
`timescale 1ns/1ps
module ffdc_top (
    input  wire logic                  clk_in,
    input  wire logic                  sys_rst_in,
    input  wire logic                  valid_in,
    input  wire logic [63:0]           double_value_in,
    input  wire logic [31:0]           single_precision_value_in,
    input  wire logic [15:0]           half_precision_value_in,
    input  wire logic [10:0]           uf11_value_in,
    input  wire logic [9:0]            uf10_value_in,
    input  wire logic [31:0]           shared_exponent_rgb_packed_in,
    output ffdc_pkg::ffdc_class_t      double_class_out,
    output ffdc_pkg::ffdc_class_t      single_class_out,
    output ffdc_pkg::ffdc_class_t      half_class_out,
    output ffdc_pkg::ffdc_class_t      uf11_class_out,
    output ffdc_pkg::ffdc_class_t      uf10_class_out,
    output logic [15:0]                uf11_half_out,
    output logic [15:0]                uf10_half_out,
    output ffdc_pkg::ffdc_rgb_t        rgb_out,
    output logic [15:0]                half_conv_out,
    output logic                       valid_out
);

    // ------------------------------------------------------------
    // Classifiers
    // ------------------------------------------------------------
    ffdc_pkg::ffdc_class_t next_double_class;
    ffdc_pkg::ffdc_class_t next_single_class;
    ffdc_pkg::ffdc_class_t next_half_class;
    ffdc_pkg::ffdc_class_t next_uf11_class;
    ffdc_pkg::ffdc_class_t next_uf10_class;

    ffdc_classify #(.EW(ffdc_pkg::DP_EXP_W), .FW(ffdc_pkg::DP_FRAC_W),
                    .BIAS(ffdc_pkg::DP_BIAS), .SGN(1)) u_dp (
        .word_in   (double_value_in),
        .class_out (next_double_class)
    );
    ffdc_classify #(.EW(ffdc_pkg::SP_EXP_W), .FW(ffdc_pkg::SP_FRAC_W),
                    .BIAS(ffdc_pkg::SP_BIAS), .SGN(1)) u_sp (
        .word_in   (single_precision_value_in),
        .class_out (next_single_class)
    );
    ffdc_classify #(.EW(ffdc_pkg::HP_EXP_W), .FW(ffdc_pkg::HP_FRAC_W),
                    .BIAS(ffdc_pkg::HP_BIAS), .SGN(1)) u_hp (
        .word_in   (half_precision_value_in),
        .class_out (next_half_class)
    );
    ffdc_classify #(.EW(ffdc_pkg::UF_EXP_W), .FW(ffdc_pkg::F11_FRAC_W),
                    .BIAS(ffdc_pkg::UF_BIAS), .SGN(0)) u_f11 (
        .word_in   (uf11_value_in),
        .class_out (next_uf11_class)
    );
    ffdc_classify #(.EW(ffdc_pkg::UF_EXP_W), .FW(ffdc_pkg::F10_FRAC_W),
                    .BIAS(ffdc_pkg::UF_BIAS), .SGN(0)) u_f10 (
        .word_in   (uf10_value_in),
        .class_out (next_uf10_class)
    );

    // ------------------------------------------------------------
    // Unsigned to half equivalent and shared RGB split
    // ------------------------------------------------------------
    // same exponent field, fraction left aligned, sign clear
    wire logic [15:0] next_uf11_half = {1'b0, uf11_value_in, 4'h0};
    wire logic [15:0] next_uf10_half = {1'b0, uf10_value_in, 5'h00};

    wire logic [4:0]  rgb_e = shared_exponent_rgb_packed_in[31:ffdc_pkg::RGB_EXP_LSB];
    ffdc_pkg::ffdc_rgb_t next_rgb;
    assign next_rgb.blue  = shared_exponent_rgb_packed_in[ffdc_pkg::RGB_BLUE_LSB +: 9];
    assign next_rgb.green = shared_exponent_rgb_packed_in[ffdc_pkg::RGB_GREEN_LSB +: 9];
    assign next_rgb.red   = shared_exponent_rgb_packed_in[ffdc_pkg::RGB_RED_LSB +: 9];
    // implied zero, no special codes, no sign
    assign next_rgb.exp   = 13'(rgb_e) - 13'(ffdc_pkg::RGB_BIAS);

    // ------------------------------------------------------------
    // Single to half conversion
    // ------------------------------------------------------------
    wire logic        cs   = single_precision_value_in[31];
    wire logic [7:0]  ce   = single_precision_value_in[30:23];
    wire logic [22:0] cf   = single_precision_value_in[22:0];
    wire logic        cnan = (&ce) & (|cf);

    // Normal path: rebias, keep 10 bits, guard and sticky below
    wire logic [4:0]  n_exp   = 5'(ce - ffdc_pkg::CVT_REBIAS);
    wire logic        n_guard = cf[12];
    wire logic        n_stick = |cf[11:0];
    wire logic        n_up    = n_guard & (n_stick | cf[13]);
    // Carry out of the fraction bumps the exponent; 30 can round to infinity
    wire logic [14:0] n_mag   = {n_exp, cf[22:13]} + 15'(n_up);

    // Denormal path: shift the full significand, clamp so it cannot wrap
    wire logic [7:0]  d_raw   = ffdc_pkg::CVT_DEN_BASE - ce;
    wire logic [7:0]  d_shift = (d_raw > ffdc_pkg::CVT_SHIFT_MAX) ?
                                ffdc_pkg::CVT_SHIFT_MAX : d_raw;
    wire logic [23:0] d_sig   = {|ce, cf};
    wire logic [48:0] d_ext   = {d_sig, 25'h0000000} >> d_shift;
    wire logic        d_up    = d_ext[24] & ((|d_ext[23:0]) | d_ext[25]);
    // Rounding into 0x400 lands exactly on the smallest normal
    wire logic [14:0] d_mag   = {5'h00, d_ext[34:25]} + 15'(d_up);

    // NaN stays NaN, sign kept everywhere
    wire logic [14:0] next_conv_mag =
        cnan                                   ? {5'h1f, ffdc_pkg::HP_QNAN_FRAC | cf[22:13]} :
        (ce >= ffdc_pkg::CVT_OVF_EXP)          ? ffdc_pkg::HP_INF_MAG :
        (ce >= ffdc_pkg::CVT_MIN_NORM_EXP)     ? n_mag :
                                                 d_mag;
    wire logic [15:0] next_half_conv = {cs, next_conv_mag};

    // ------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------
    // capture on valid, clear on reset; data outputs hold otherwise, valid_out follows valid_in
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            valid_out        <= 1'b0;
            double_class_out <= '0;
            single_class_out <= '0;
            half_class_out   <= '0;
            uf11_class_out   <= '0;
            uf10_class_out   <= '0;
            uf11_half_out    <= 16'h0000;
            uf10_half_out    <= 16'h0000;
            rgb_out          <= '0;
            half_conv_out    <= 16'h0000;
        end else begin
            valid_out <= valid_in;
            if (valid_in) begin
                double_class_out <= next_double_class;
                single_class_out <= next_single_class;
                half_class_out   <= next_half_class;
                uf11_class_out   <= next_uf11_class;
                uf10_class_out   <= next_uf10_class;
                uf11_half_out    <= next_uf11_half;
                uf10_half_out    <= next_uf10_half;
                rgb_out          <= next_rgb;
                half_conv_out    <= next_half_conv;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions and covers
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_dp_normal_exp;
        valid_in && (double_value_in[62:52] != 11'h000) && (double_value_in[62:52] != 11'h7ff)
        |=> double_class_out.exp == 13'($past(double_value_in[62:52])) - 13'sd1023
            && double_class_out.sig[52];
    endproperty
    a_dp_normal_exp: assert property (p_dp_normal_exp) else $error("double exponent wrong");

    property p_dp_nan;
        valid_in && (&double_value_in[62:52]) && (|double_value_in[51:0])
        |=> double_class_out.nan && !double_class_out.inf;
    endproperty
    a_dp_nan: assert property (p_dp_nan) else $error("double NaN missed");

    property p_sp_denorm;
        valid_in && single_precision_value_in[30:23] == 8'h00 && |single_precision_value_in[22:0]
        |=> single_class_out.denorm && single_class_out.exp == -13'sd126;
    endproperty
    a_sp_denorm: assert property (p_sp_denorm) else $error("single denormal wrong");

    property p_sp_inf;
        valid_in && single_precision_value_in[30:0] == 31'h7f800000
        |=> single_class_out.inf && single_class_out.sign == $past(single_precision_value_in[31]);
    endproperty
    a_sp_inf: assert property (p_sp_inf) else $error("single infinity wrong");

    property p_hp_zero;
        valid_in && half_precision_value_in[14:0] == 15'h0000
        |=> half_class_out.zero && half_class_out.sign == $past(half_precision_value_in[15]);
    endproperty
    a_hp_zero: assert property (p_hp_zero) else $error("half zero wrong");

    property p_cvt_tie_even;
        valid_in && single_precision_value_in[30:23] == 8'h7f
        && single_precision_value_in[12:0] == 13'h1000 |=> half_conv_out[0] == 1'b0;
    endproperty
    a_cvt_tie_even: assert property (p_cvt_tie_even) else $error("tie not even");

    property p_cvt_overflow;
        valid_in && single_precision_value_in[30:23] >= 8'h8f && !(&single_precision_value_in[30:23])
        |=> half_conv_out[14:0] == 15'h7c00;
    endproperty
    a_cvt_overflow: assert property (p_cvt_overflow) else $error("no overflow");

    property p_cvt_min_norm;
        valid_in && single_precision_value_in[30:0] == 31'h38800000
        |=> half_conv_out[14:0] == 15'h0400;
    endproperty
    a_cvt_min_norm: assert property (p_cvt_min_norm) else $error("113 not exponent 1");

    property p_f11_max;
        valid_in && uf11_value_in == 11'h7bf |=> uf11_half_out == 16'h7bf0
                                                 && (uf11_class_out.sig << 9) == 53'hfe00
                                                 && uf11_class_out.exp == 13'sd15;
    endproperty
    a_f11_max: assert property (p_f11_max) else $error("eleven bit max wrong");

    property p_f10_max;
        valid_in && uf10_value_in == 10'h3df |=> uf10_half_out == 16'h7be0
                                                 && (uf10_class_out.sig << 10) == 53'hfc00;
    endproperty
    a_f10_max: assert property (p_f10_max) else $error("ten bit max wrong");

    property p_uf_unsigned;
        valid_out |-> !uf11_class_out.sign && !uf10_class_out.sign;
    endproperty
    a_uf_unsigned: assert property (p_uf_unsigned) else $error("unsigned gave sign");

    property p_uf_inf;
        valid_in && uf11_value_in == 11'h7c0 |=> uf11_class_out.inf && !uf11_class_out.nan;
    endproperty
    a_uf_inf: assert property (p_uf_inf) else $error("eleven bit infinity missed");

    property p_rgb_fields;
        valid_in |=> rgb_out.red == $past(shared_exponent_rgb_packed_in[8:0])
                     && rgb_out.blue == $past(shared_exponent_rgb_packed_in[26:18])
                     && rgb_out.exp == 13'($past(shared_exponent_rgb_packed_in[31:27])) - 13'sd15;
    endproperty
    a_rgb_fields: assert property (p_rgb_fields) else $error("shared RGB split wrong");

    property p_cvt_nan;
        valid_in && cnan |=> (&half_conv_out[14:10]) && (|half_conv_out[9:0]);
    endproperty
    a_cvt_nan: assert property (p_cvt_nan) else $error("NaN lost in conversion");

    property p_reset_clear;
        // Reset is the antecedent here, so the default disable must not apply
        @(posedge clk_in) disable iff (1'b0)
            sys_rst_in |=> !valid_out && half_conv_out == 16'h0000;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear");

    c_denorm_conv: cover property (valid_in && single_precision_value_in[30:23] < 8'h71
                                   && single_precision_value_in[30:23] != 8'h00);
    c_round_carry: cover property (valid_in && n_up && (&cf[22:13]));
    c_dp_denorm:   cover property (valid_in ##1 double_class_out.denorm);
    c_back2back:   cover property (valid_in [*3]);

endmodule

// file: tb/ffdc_stage_model.sv
// Model of the pipeline stage that takes converted results from the block.
// Assumes each clk_in cycle with valid high carries one result.
`timescale 1ns/1ps
module ffdc_stage_model (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        valid_in,
    input  wire logic [15:0] half_in,
    output logic [15:0]      rx_half_out,
    output int               rx_count_out
);
    // ------------------------------------------------------------
    // Result capture
    // ------------------------------------------------------------
    // Counts every cycle with valid high so a stray or a lost valid shows in the total
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rx_count_out <= 0;
            rx_half_out  <= 16'h0000;
        end else if (valid_in) begin
            rx_count_out <= rx_count_out + 1;
            rx_half_out  <= half_in;
        end
    end
endmodule

// file: tb/ffdc_top_test.sv
// Self-checking bench for the float decoder and converter.
// Assumes one 40 MHz clock and inputs driven at the falling edge.
`timescale 1ns/1ps
module ffdc_top_test;
    logic clk_in, sys_rst_in, valid_in, vout;
    logic [63:0] d_in;
    logic [31:0] s_in, rgb_in;
    logic [15:0] h_in, h11, h10, hconv, rx_half;
    logic [10:0] u11_in;
    logic [9:0]  u10_in;
    ffdc_pkg::ffdc_class_t dc, sc, hc, c11, c10;
    ffdc_pkg::ffdc_rgb_t   rgb;
    int rx_count, applies = 0, checks = 0, miscompares = 0;
    // Single inputs and expected halves for the rounding table
    logic [31:0] cv_in [11] = '{32'h3f800000, 32'h3f801000, 32'h3f803000, 32'h3f801001,
        32'h38800000, 32'h38000000, 32'h477fe000, 32'h47800000, 32'h477ff000,
        32'h33800000, 32'h33000000};
    logic [15:0] cv_out [11] = '{16'h3c00, 16'h3c00, 16'h3c02, 16'h3c01, 16'h0400,
        16'h0200, 16'h7bff, 16'h7c00, 16'h7c00, 16'h0001, 16'h0000};

    ffdc_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .valid_in(valid_in),
        .double_value_in(d_in), .single_precision_value_in(s_in),
        .half_precision_value_in(h_in), .uf11_value_in(u11_in), .uf10_value_in(u10_in),
        .shared_exponent_rgb_packed_in(rgb_in), .double_class_out(dc),
        .single_class_out(sc), .half_class_out(hc), .uf11_class_out(c11),
        .uf10_class_out(c10), .uf11_half_out(h11), .uf10_half_out(h10),
        .rgb_out(rgb), .half_conv_out(hconv), .valid_out(vout));
    ffdc_stage_model stage (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .valid_in(vout),
        .half_in(hconv), .rx_half_out(rx_half), .rx_count_out(rx_count));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [127:0] seen, input logic [127:0] expv);
        checks++;
        if (seen !== expv) begin
            miscompares++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, expv);
        end
    endtask
    // Flags are sign, nan, inf, zero, denorm in that order
    task automatic chk(input ffdc_pkg::ffdc_class_t seen, input logic [4:0] f, input int e,
                       input logic [52:0] sg);
        check(seen, {f, 13'(e), sg});
    endtask
    // One valid cycle; valid_out is looked at while it stands
    task automatic run(input logic [63:0] d, input logic [31:0] s, input logic [15:0] h,
                       input logic [10:0] a, input logic [9:0] b, input logic [31:0] r);
        @(negedge clk_in);
        {d_in, s_in, h_in, u11_in, u10_in, rgb_in} = {d, s, h, a, b, r};
        valid_in = 1'b1;
        @(negedge clk_in);
        valid_in = 1'b0;
        applies++;
        check(vout, 1'b1);
    endtask
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // normal decode
    task automatic t_normal();
        run(64'hc008000000000000, 32'hc0400000, 16'hc200, 11'h420, 10'h210, 32'ha6a8ab23);
        chk(dc, 5'b10000, 1, 53'h18000000000000);
        chk(sc, 5'b10000, 1, 53'hc00000);
        chk(hc, 5'b10000, 1, 53'h600);
        chk(c11, 5'b00000, 1, 53'h60);
        chk(c10, 5'b00000, 1, 53'h30);
        check({h11, h10}, 32'h42004200);
        check(rgb, ffdc_pkg::ffdc_rgb_t'{13'sd5, 9'h123, 9'h055, 9'h1aa});
        check(hconv, 16'hc200);
    endtask
    task automatic t_denorm();
        run(64'h1, 32'h80000001, 16'h8001, 11'h001, 10'h001, 32'h00000001);
        chk(dc, 5'b00001, -1022, 53'h1);
        chk(sc, 5'b10001, -126, 53'h1);
        chk(hc, 5'b10001, -14, 53'h1);
        chk(c11, 5'b00001, -14, 53'h1);
        chk(c10, 5'b00001, -14, 53'h1);
        check({h11, h10, hconv}, 48'h001000208000);
        check(rgb, ffdc_pkg::ffdc_rgb_t'{-13'sd15, 9'h001, 9'h000, 9'h000});
    endtask
    // infinities and a full shared word
    task automatic t_inf();
        run(64'hfff0000000000000, 32'hff800000, 16'hfc00, 11'h7c0, 10'h3e0, 32'hffffffff);
        chk(dc, 5'b10100, 1024, 53'h0);
        chk(sc, 5'b10100, 128, 53'h0);
        chk(hc, 5'b10100, 16, 53'h0);
        chk(c11, 5'b00100, 16, 53'h0);
        chk(c10, 5'b00100, 16, 53'h0);
        check({h11, h10, hconv}, 48'h7c007c00fc00);
        check(rgb, ffdc_pkg::ffdc_rgb_t'{13'sd16, 9'h1ff, 9'h1ff, 9'h1ff});
    endtask
    task automatic t_nan();
        run(64'hfff0000000000001, 32'hff800001, 16'hfc01, 11'h7c1, 10'h3e1, 32'h0);
        check({dc.nan, sc.nan, hc.nan, c11.nan, c10.nan}, 5'h1f);
        check({dc.inf, sc.inf, hc.inf, c11.inf, c10.inf}, 5'h00);
        check({c11.sign, c10.sign}, 2'b00);
        check({hconv[14:10], |hconv[9:0]}, 6'h3f);
    endtask
    task automatic t_zero();
        run(64'h8000000000000000, 32'h80000000, 16'h8000, 11'h0, 10'h0, 32'h0);
        chk(dc, 5'b10010, -1022, 53'h0);
        chk(sc, 5'b10010, -126, 53'h0);
        chk(hc, 5'b10010, -14, 53'h0);
        chk(c11, 5'b00010, -14, 53'h0);
        check(hconv, 16'h8000);
    endtask
    task automatic t_max();
        run(64'h0, 32'h0, 16'h0, 11'h7bf, 10'h3df, 32'h0);
        check(64'(c11.sig) << (c11.exp - 6), 65024);
        check(64'(c10.sig) << (c10.exp - 5), 64512);
        check({h11, h10}, 32'h7bf07be0);
    endtask
    // rounding table, ties, carry into infinity, denormals
    task automatic t_conv();
        for (int i = 0; i < 11; i++) begin
            run(64'h0, cv_in[i], 16'h0, 11'h0, 10'h0, 32'h0);
            check(hconv, cv_out[i]);
            // Stage takes the result one edge after valid_out rises
            @(negedge clk_in);
            check(rx_half, cv_out[i]);
        end
    endtask
    task automatic t_burst();
        for (int i = 2; i < 5; i++) begin
            @(negedge clk_in);
            s_in     = cv_in[i];
            valid_in = 1'b1;
            applies++;
            if (i > 2) begin
                check({vout, hconv}, {1'b1, cv_out[i - 1]});
            end
        end
        @(negedge clk_in);
        valid_in = 1'b0;
        check({vout, hconv}, {1'b1, cv_out[4]});
    endtask
    // hold without valid, then synchronous clear
    task automatic t_hold();
        @(negedge clk_in);
        s_in = 32'h3f800000;
        repeat (2) @(negedge clk_in);
        check({vout, hconv}, {1'b0, cv_out[10]});
        check(rx_count, applies);
        sys_rst_in = 1'b1;
        @(negedge clk_in);
        sys_rst_in = 1'b0;
        check({vout, hconv, dc}, 88'h0);
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // Run needs under 100 cycles; 2000 leaves a wide margin
    initial begin
        #(25 * 2000);
        miscompares++;
        finish_test();
    end
    initial begin
        {sys_rst_in, valid_in, d_in, s_in, h_in, u11_in, u10_in, rgb_in} = '0;
        sys_rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        t_normal();
        t_denorm();
        t_inf();
        t_nan();
        t_zero();
        t_max();
        t_burst();
        t_conv();
        t_hold();
        finish_test();
    end
endmodule
